// ==== src/smpa_core.v ====
// SPI slave command logic with status register, write protection and array
`timescale 1ns/1ps
`default_nettype none
`include "smpa_regs.vh"
module smpa_core #(
   parameter ADDR_W = 15,
   parameter DEPTH  = 32768
) (
   input  wire clk_sys,
   input  wire rst,
   input  wire spi_cs_n,
   input  wire spi_sck,
   input  wire spi_si,
   input  wire wp_n,
   output reg  spi_so,
   output reg  spi_so_oe
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire cs_n_s;
   wire sck_s;
   wire si_s;
   wire wp_n_s;
   smpa_sync #(.RESET_VALUE(1'b1)) u_cs (.clk_sys(clk_sys), .rst(rst), .din(spi_cs_n), .dout(cs_n_s));
   smpa_sync #(.RESET_VALUE(1'b0)) u_sck (.clk_sys(clk_sys), .rst(rst), .din(spi_sck), .dout(sck_s));
   smpa_sync #(.RESET_VALUE(1'b0)) u_si (.clk_sys(clk_sys), .rst(rst), .din(spi_si), .dout(si_s));
   smpa_sync #(.RESET_VALUE(1'b1)) u_wp (.clk_sys(clk_sys), .rst(rst), .din(wp_n), .dout(wp_n_s));

   reg        sck_d;
   reg        cs_d;
   wire       sck_rise = sck_s & ~sck_d;
   wire       sck_fall = ~sck_s & sck_d;
   wire       cs_fall  = cs_d & ~cs_n_s;
   wire       cs_rise  = ~cs_d & cs_n_s;
   wire       active   = ~cs_n_s;

   // ----------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------
   localparam ST_OPCODE = 3'h0;
   localparam ST_ADDR_H = 3'h1;
   localparam ST_ADDR_L = 3'h2;
   localparam ST_DUMMY  = 3'h3;
   localparam ST_RDATA  = 3'h4;
   localparam ST_WDATA  = 3'h5;
   localparam ST_STATW  = 3'h6;
   localparam ST_IDLE   = 3'h7;

   // Array and guard bits model retained storage: reset leaves them alone
   reg  [7:0]        mem [0:DEPTH-1];
   reg               pin_guard_enable;
   reg               block_guard_hi;
   reg               block_guard_lo;
   reg               write_latch_flag;
   reg  [2:0]        state;
   reg  [2:0]        bit_cnt;
   reg  [7:0]        shift_in;
   reg  [7:0]        shift_out;
   reg  [7:0]        opcode;
   reg  [ADDR_W-1:0] addr;
   reg               write_halted;
   reg               end_clears_latch;
   reg               load_pending;
   reg               load_is_status;

   wire [7:0] next_byte = {shift_in[6:0], si_s};
   wire       byte_done = sck_rise & (bit_cnt == 3'h7);

   wire [7:0] protection_status = {pin_guard_enable, 3'b000,
                                   block_guard_hi, block_guard_lo,
                                   write_latch_flag, 1'b0};

   // Protected region decode
   function guarded;
      input [ADDR_W-1:0] a;
      input [1:0]        g;
      begin
         case (g)
            2'b00:   guarded = 1'b0;
            2'b01:   guarded = (a >= `SMPA_QUARTER_BASE);
            2'b10:   guarded = (a >= `SMPA_HALF_BASE);
            default: guarded = 1'b1;
         endcase
      end
   endfunction

   wire addr_guarded = guarded(addr, {block_guard_hi, block_guard_lo});
   // Pin only gates status writes, never the array
   wire status_locked = pin_guard_enable & ~wp_n_s;
   wire [ADDR_W-1:0] addr_inc = (addr == `SMPA_ADDR_LAST) ? {ADDR_W{1'b0}}
                                : addr + {{(ADDR_W-1){1'b0}}, 1'b1};
   wire [ADDR_W-1:0] next_addr_low = {addr[ADDR_W-1:8], next_byte};

   // ----------------------------------------------------------------
   // Edge trackers
   // ----------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sck_d <= 1'b0;
         cs_d  <= 1'b1;
      end else begin
         sck_d <= sck_s;
         cs_d  <= cs_n_s;
      end
   end

   // ----------------------------------------------------------------
   // Array write port
   // ----------------------------------------------------------------
   // Commit on eighth clock only when latch set and region free
   always @(posedge clk_sys) begin
      if (active && state == ST_WDATA && byte_done && write_latch_flag
          && !write_halted && !addr_guarded) begin
         mem[addr] <= next_byte;
      end
   end

   // ----------------------------------------------------------------
   // Retained guard bits
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (active && state == ST_STATW && byte_done && write_latch_flag
          && !status_locked) begin
         pin_guard_enable <= next_byte[`SMPA_BIT_PIN_GUARD];
         block_guard_hi   <= next_byte[`SMPA_BIT_GUARD_HI];
         block_guard_lo   <= next_byte[`SMPA_BIT_GUARD_LO];
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         write_latch_flag <= 1'b0;
         state            <= ST_OPCODE;
         bit_cnt          <= 3'h0;
         shift_in         <= 8'h00;
         opcode           <= 8'h00;
         addr             <= {ADDR_W{1'b0}};
         write_halted     <= 1'b0;
         end_clears_latch <= 1'b0;
         load_pending     <= 1'b0;
         load_is_status   <= 1'b0;
      end else if (cs_rise || !active) begin
         // Frame end; latch cleared after latch-clear, status or array write
         if (cs_rise && end_clears_latch) begin
            write_latch_flag <= 1'b0;
         end
         state            <= ST_OPCODE;
         bit_cnt          <= 3'h0;
         write_halted     <= 1'b0;
         end_clears_latch <= 1'b0;
         load_pending     <= 1'b0;
      end else begin
         load_pending <= 1'b0;
         if (cs_fall) begin
            state   <= ST_OPCODE;
            bit_cnt <= 3'h0;
         end else if (sck_rise) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_byte;
            if (bit_cnt == 3'h7) begin
               case (state)
                  ST_OPCODE: begin
                     opcode <= next_byte;
                     case (next_byte)
                        `SMPA_OP_LATCH_SET: begin
                           write_latch_flag <= 1'b1;
                           state            <= ST_IDLE;
                        end
                        `SMPA_OP_LATCH_CLEAR: begin
                           end_clears_latch <= 1'b1;
                           state            <= ST_IDLE;
                        end
                        `SMPA_OP_STATUS_READ: begin
                           load_pending   <= 1'b1;
                           load_is_status <= 1'b1;
                           state          <= ST_RDATA;
                        end
                        `SMPA_OP_STATUS_WRITE: begin
                           end_clears_latch <= 1'b1;
                           state            <= ST_STATW;
                        end
                        `SMPA_OP_READ,
                        `SMPA_OP_FAST_FETCH,
                        `SMPA_OP_WRITE: begin
                           end_clears_latch <= (next_byte == `SMPA_OP_WRITE);
                           state            <= ST_ADDR_H;
                        end
                        default: state <= ST_IDLE;
                     endcase
                  end
                  ST_ADDR_H: begin
                     // Top address bit dropped
                     addr  <= {next_byte[ADDR_W-9:0], addr[7:0]};
                     state <= ST_ADDR_L;
                  end
                  ST_ADDR_L: begin
                     addr <= next_addr_low;
                     if (opcode == `SMPA_OP_WRITE) begin
                        state <= ST_WDATA;
                     end else if (opcode == `SMPA_OP_FAST_FETCH) begin
                        state <= ST_DUMMY;
                     end else begin
                        load_pending   <= 1'b1;
                        load_is_status <= 1'b0;
                        state          <= ST_RDATA;
                     end
                  end
                  ST_DUMMY: begin
                     load_pending   <= 1'b1;
                     load_is_status <= 1'b0;
                     state          <= ST_RDATA;
                  end
                  ST_RDATA: begin
                     // Input bits ignored; array reads fetch the next byte, status read ends
                     if (opcode != `SMPA_OP_STATUS_READ) begin
                        addr         <= addr_inc;
                        load_pending <= 1'b1;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_WDATA: begin
                     if (addr_guarded || write_halted) begin
                        write_halted <= 1'b1;
                     end else begin
                        addr <= addr_inc;
                     end
                  end
                  ST_STATW: state <= ST_IDLE;
                  default:  state <= ST_IDLE;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial output, driven on falling clock
   // ----------------------------------------------------------------
   // A loaded byte's first bit waits for the next falling edge so the prior byte's last bit holds
   reg load_armed;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shift_out  <= 8'h00;
         spi_so     <= 1'b0;
         spi_so_oe  <= 1'b0;
         load_armed <= 1'b0;
      end else if (!active || cs_rise) begin
         spi_so_oe  <= 1'b0;
         spi_so     <= 1'b0;
         load_armed <= 1'b0;
      end else begin
         if (load_pending) begin
            load_armed <= 1'b1;
            shift_out  <= load_is_status ? protection_status : mem[addr];
         end else if (sck_fall && load_armed) begin
            load_armed <= 1'b0;
            spi_so     <= shift_out[7];
            shift_out  <= {shift_out[6:0], 1'b0};
            spi_so_oe  <= 1'b1;
         end else if (sck_fall && state == ST_RDATA) begin
            spi_so    <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end else if (sck_fall && state != ST_RDATA) begin
            // Released line parks low so a stale last bit never lingers
            spi_so_oe <= 1'b0;
            spi_so    <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== src/smpa_regs.vh ====
// Constants for the protected serial memory slave
`ifndef SMPA_REGS_VH
`define SMPA_REGS_VH
`define SMPA_OP_LATCH_SET    8'h06
`define SMPA_OP_LATCH_CLEAR  8'h04
`define SMPA_OP_STATUS_READ  8'h05
`define SMPA_OP_STATUS_WRITE 8'h01
`define SMPA_OP_READ         8'h03
`define SMPA_OP_FAST_FETCH   8'h0B
`define SMPA_OP_WRITE        8'h02
`define SMPA_STATUS_RESET    8'h00
`define SMPA_BIT_PIN_GUARD   7
`define SMPA_BIT_GUARD_HI    3
`define SMPA_BIT_GUARD_LO    2
`define SMPA_BIT_LATCH       1
`define SMPA_QUARTER_BASE    15'h6000
`define SMPA_HALF_BASE       15'h4000
`define SMPA_ADDR_LAST       15'h7FFF
`endif

// ==== src/smpa_sync.v ====
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module smpa_sync #(
   parameter RESET_VALUE = 1'b0
) (
   input  wire clk_sys,
   input  wire rst,
   input  wire din,
   output reg  dout
);
   reg stage1;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1 <= RESET_VALUE;
         dout   <= RESET_VALUE;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/smpa_core_properties.sv ====
// Port-level temporal checks for the protected serial memory slave
`timescale 1ns/1ps
`default_nettype none
module smpa_core_checker (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic spi_cs_n,
   input  wire logic spi_sck,
   input  wire logic spi_si,
   input  wire logic wp_n,
   input  wire logic spi_so,
   input  wire logic spi_so_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // -------------------------------------------------
   // Sequences and properties
   // -------------------------------------------------
   sequence s_cs_rise;
      $rose(spi_cs_n);
   endsequence
   sequence s_sck_held;
      spi_sck ##1 spi_sck;
   endsequence
   property p_float_after_end;
      s_cs_rise |-> ##[0:4] !spi_so_oe;
   endproperty
   property p_idle_off;
      spi_cs_n [*5] |-> !spi_so_oe;
   endproperty
   property p_so_zero_off;
      !spi_so_oe |-> !spi_so;
   endproperty
   // Output bit may only move when the clock was low the cycle before
   property p_so_after_fall;
      spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> !$past(spi_sck);
   endproperty
   property p_so_stable_high;
      s_sck_held ##0 (spi_so_oe && $past(spi_so_oe)) |-> $stable(spi_so);
   endproperty
   property p_oe_start_selected;
      $rose(spi_so_oe) |-> !spi_cs_n && !$past(spi_cs_n, 8);
   endproperty
   property p_oe_start_after_fall;
      $rose(spi_so_oe) |-> !$past(spi_sck);
   endproperty
   property p_oe_byte;
      $rose(spi_so_oe) |-> spi_so_oe [*8];
   endproperty
   a_float_after_end: assert property (p_float_after_end)
      else $error("output enable outlived chip select");
   a_idle_off: assert property (p_idle_off)
      else $error("output driven while deselected");
   a_so_zero_off: assert property (p_so_zero_off)
      else $error("output not low while released");
   a_so_after_fall: assert property (p_so_after_fall)
      else $error("output bit moved away from clock fall");
   a_so_stable_high: assert property (p_so_stable_high)
      else $error("output bit moved while clock high");
   a_oe_start_selected: assert property (p_oe_start_selected)
      else $error("output enabled without a selected frame");
   a_oe_start_after_fall: assert property (p_oe_start_after_fall)
      else $error("output enabled away from clock fall");
   a_oe_byte: assert property (p_oe_byte)
      else $error("output enable shorter than a bit");
endmodule
bind smpa_core smpa_core_checker u_checker (
   .clk_sys   (clk_sys),
   .rst       (rst),
   .spi_cs_n  (spi_cs_n),
   .spi_sck   (spi_sck),
   .spi_si    (spi_si),
   .wp_n      (wp_n),
   .spi_so    (spi_so),
   .spi_so_oe (spi_so_oe)
);
`default_nettype wire

// ==== tb/smpa_spi_master.sv ====
// Mode 0 serial bus master model facing the memory slave
`timescale 1ns/1ps
`default_nettype none
module smpa_spi_master (
   input  wire logic clk_sys,
   output var  logic spi_cs_n,
   output var  logic spi_sck,
   output var  logic spi_si,
   input  wire logic spi_so,
   input  wire logic spi_so_oe
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sck  = 1'b0;
      spi_si   = 1'b0;
   end
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Gaps let the slave's synchronisers see every select edge
   task automatic open_frame;
      cycles(4);
      spi_cs_n <= 1'b0;
      cycles(4);
   endtask
   task automatic close_frame;
      cycles(2);
      spi_cs_n <= 1'b1;
   endtask
   // -------------------------------------------------
   // Clock low 5 cycles, high 3: 400 ns period
   // -------------------------------------------------
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_si <= tx[i];
         cycles(4);
         @(negedge clk_sys);
         // Released line reads inverted, so a parked-low line reads as 1
         rx[i] = spi_so_oe ? spi_so : ~spi_so;
         @(posedge clk_sys);
         spi_sck <= 1'b1;
         cycles(3);
         spi_sck <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/test_spi_memory_protect_access.sv ====
// Self-checking bench for the protected serial memory slave
`timescale 1ns/1ps
`default_nettype none
`include "smpa_regs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_spi_memory_protect_access;
   logic clk_sys, rst, spi_cs_n, spi_sck, spi_si, wp_n, spi_so, spi_so_oe;
   int          miscompares = 0;
   int          n_tests     = 0;
   logic [7:0]  mem_exp [int];
   logic [7:0]  sr;
   logic [7:0]  rx;
   logic        latch;
   logic [14:0] base [3] = '{15'h5FFD, 15'h7FFD, 15'h3FFE};
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   smpa_core DUT (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .spi_cs_n  (spi_cs_n),
      .spi_sck   (spi_sck),
      .spi_si    (spi_si),
      .wp_n      (wp_n),
      .spi_so    (spi_so),
      .spi_so_oe (spi_so_oe)
   );
   smpa_spi_master u_mst (
      .clk_sys   (clk_sys),
      .spi_cs_n  (spi_cs_n),
      .spi_sck   (spi_sck),
      .spi_si    (spi_si),
      .spi_so    (spi_so),
      .spi_so_oe (spi_so_oe)
   );
   // -------------------------------------------------
   // Transactions and expectations
   // -------------------------------------------------
   task automatic one_cmd(input logic [7:0] op);
      u_mst.open_frame;
      u_mst.xfer(op, rx);
      u_mst.close_frame;
      if (op == `SMPA_OP_LATCH_SET) latch = 1'b1;
      if (op == `SMPA_OP_LATCH_CLEAR) latch = 1'b0;
   endtask
   function automatic logic guarded(input logic [14:0] a);
      case (sr[3:2])
         2'b01: return a >= `SMPA_QUARTER_BASE;
         2'b10: return a >= `SMPA_HALF_BASE;
         2'b11: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic status_write(input logic [7:0] v);
      one_cmd(`SMPA_OP_LATCH_SET);
      u_mst.open_frame;
      u_mst.xfer(`SMPA_OP_STATUS_WRITE, rx);
      u_mst.xfer(v, rx);
      u_mst.close_frame;
      if (!(sr[7] && !wp_n)) sr = v & 8'h8C;
      latch = 1'b0;
   endtask
   task automatic status_check;
      u_mst.open_frame;
      u_mst.xfer(`SMPA_OP_STATUS_READ, rx);
      u_mst.xfer(8'h00, rx);
      u_mst.close_frame;
      `CHK("status", sr | {6'h00, latch, 1'b0}, rx)
   endtask
   task automatic mem_write(input logic [14:0] a, input int n, input logic arm);
      logic       stop;
      logic [7:0] d;
      stop = 1'b0;
      if (arm) one_cmd(`SMPA_OP_LATCH_SET);
      u_mst.open_frame;
      u_mst.xfer(`SMPA_OP_WRITE, rx);
      u_mst.xfer({1'($urandom), a[14:8]}, rx);
      u_mst.xfer(a[7:0], rx);
      repeat (n) begin
         d = 8'($urandom);
         u_mst.xfer(d, rx);
         if (guarded(a)) stop = 1'b1;
         if (!stop && latch) mem_exp[a] = d;
         if (!stop) a = a + 15'h0001;
      end
      u_mst.close_frame;
      latch = 1'b0;
   endtask
   task automatic mem_read(input logic [14:0] a, input int n, input logic fast);
      u_mst.open_frame;
      u_mst.xfer(fast ? `SMPA_OP_FAST_FETCH : `SMPA_OP_READ, rx);
      u_mst.xfer({1'b1, a[14:8]}, rx);
      u_mst.xfer(a[7:0], rx);
      if (fast) u_mst.xfer(8'($urandom), rx);
      repeat (n) begin
         u_mst.xfer(8'($urandom), rx);
         if (mem_exp.exists(a)) `CHK("array", mem_exp[a], rx)
         a = a + 15'h0001;
      end
      u_mst.close_frame;
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk_sys);
      miscompares++;
      complete_run;
   end
   initial begin
      void'($urandom(56115));
      rst = 1'b1;
      wp_n = 1'b1;
      latch = 1'b0;
      sr = 8'h00;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      status_write(8'h00);
      status_check;
      status_write(8'hFF);
      status_check;
      one_cmd(`SMPA_OP_LATCH_SET);
      status_check;
      one_cmd(`SMPA_OP_LATCH_CLEAR);
      status_check;
      // Low pin with guard enabled must refuse this one
      @(posedge clk_sys) wp_n <= 1'b0;
      status_write(8'h00);
      status_check;
      @(posedge clk_sys) wp_n <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         status_write({1'($urandom), 3'h0, 2'(i), 2'h0});
         @(posedge clk_sys) wp_n <= 1'($urandom);
         status_check;
         mem_write(base[i % 3], 6, i != 5);
         mem_read(base[i % 3], 8, i[0]);
         @(posedge clk_sys) wp_n <= 1'b1;
      end
      complete_run;
   end
endmodule
`default_nettype wire
